/* hdl/cct_defs.svh */
// offsets, field positions, reset values and codes of the capture/compare timer
`ifndef CCT_DEFS_SVH
`define CCT_DEFS_SVH

`define CCT_OFF_RUN       8'h00
`define CCT_OFF_MODE      8'h04
`define CCT_OFF_FLOP      8'h08
`define CCT_OFF_CMPA      8'h0c
`define CCT_OFF_CMPB      8'h10
`define CCT_OFF_CAPA      8'h14
`define CCT_OFF_CAPB      8'h18
`define CCT_OFF_CNT       8'h1c
`define CCT_OFF_STAT      8'h20

`define CCT_RUN_EN        0
`define CCT_RUN_PRS       2
`define CCT_RUN_TRG       5
`define CCT_RUN_CSS       6
`define CCT_RUN_DBUF      7

`define CCT_MODE_CLK_LO   0
`define CCT_MODE_CLE      2
`define CCT_MODE_CPM_LO   3
`define CCT_MODE_SWCAP    6

`define CCT_FLOP_OP_LO    0
`define CCT_FLOP_TOGA     2
`define CCT_FLOP_TOGB     3
`define CCT_FLOP_TOGCAP   4
`define CCT_FLOP_STATE    6

`define CCT_STAT_OVF      0
`define CCT_STAT_STARTED  1
`define CCT_STAT_FLOP     2

`define CCT_RST_RUN       8'h00
`define CCT_RST_MODE      8'h00
`define CCT_RST_TOG       3'b000
`define CCT_RST_FLOP      1'b0

`define CCT_CPM_OFF       2'b00
`define CCT_CPM_RISE_FALL 2'b01
`define CCT_CPM_TRIG      2'b10

`define CCT_OP_TOGGLE     2'b00
`define CCT_OP_SET        2'b01
`define CCT_OP_CLEAR      2'b10
`define CCT_OP_KEEP       2'b11

`define CCT_RESP_OKAY     2'b00
`define CCT_RESP_SLVERR   2'b10

`define CCT_PRS_DIV_W     7
`define CCT_PRS_TAPS      4

`endif

/* hdl/cct_pkg.sv */
// types shared by the capture/compare timer
package cct_pkg;

    typedef enum logic [1:0] {
        CCT_WR_IDLE = 2'b01,
        CCT_WR_RESP = 2'b10
    } cct_wr_e;

    typedef enum logic [3:0] {
        CCT_R_RUN  = 4'h0,
        CCT_R_MODE = 4'h1,
        CCT_R_FLOP = 4'h2,
        CCT_R_CMPA = 4'h3,
        CCT_R_CMPB = 4'h4,
        CCT_R_CAPA = 4'h5,
        CCT_R_CAPB = 4'h6,
        CCT_R_CNT  = 4'h7,
        CCT_R_STAT = 4'h8,
        CCT_R_NONE = 4'hf
    } cct_reg_e;

    typedef logic [31:0] cct_word_t;

endpackage : cct_pkg

/* hdl/cct_prescaler.sv */
// prescaler giving one-cycle tick enables at clk/2, /8, /32 and /128
`timescale 1ns/1ps
`include "cct_defs.svh"

module cct_prescaler #(
    parameter int DIV_W = `CCT_PRS_DIV_W,
    parameter int NTAP  = `CCT_PRS_TAPS
) (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            nrst,
    // control
    input  wire logic            enable,
    // tick enables, tap k divides by 2**(2k+1)
    output logic [NTAP-1:0]      tick
);
    import cct_pkg::*;

    logic [DIV_W-1:0] div_r;

    if (2 * NTAP - 1 > DIV_W) begin : g_chk
        $error("prescaler too narrow for the taps asked");
    end

    // stopping clears the divider so the first tick after start is a full period
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_r <= '0;
        end else if (!enable) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    for (genvar k = 0; k < NTAP; k++) begin : g_tap
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                tick[k] <= 1'b0;
            end else begin
                tick[k] <= enable & (&div_r[2*k:0]);
            end
        end
    end

endmodule : cct_prescaler

/* hdl/cct_timer.sv */
// 16-bit capture/compare timer channel with an AXI4-Lite register slave
// Functional notes
// - interval mode: compare-B match raises the match-B interrupt every period
// - event mode: counter increments on each rising edge of the input pin
// - software capture command copies the counter into capture register A
// - pulse mode: flop toggles on compare-A match and on compare-B match, drives pin
// - square-wave polarity follows the flop value software preloads
// - double buffering: compare A writes buffered, loaded on each compare-B match; the load is skipped when a compare A write lands in the match cycle
// - measurement: rising edge captures into A, following falling edge into B
// - measurement and triggered one-shot: counter free-runs on a prescaler tick
// - counter overflow is flagged so a missing input edge is detectable
// - triggered one-shot: rising input edge latches the counter into capture A
// - triggered one-shot: rising input edge raises the capture-B interrupt
// - both toggle enables set make the flop toggle on both matches, one pulse
// - compare-B match during one-shot raises the match-B interrupt
// - flop may also toggle on a capture into capture register A
// - trigger select and count source select set: count on input rising edges
// - external start mode: counting begins only at a rising input edge
// - compare A never matches while it holds zero
// - compare B matches only with clear-on-match or its toggle enable set
// - match-A interrupt only with capture mode off; toggling still works
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "cct_defs.svh"

module cct_timer #(
    parameter int CNT_W  = 16,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              nrst,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // axi4-lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // timer pins
    input  wire logic              timer_input_pin,
    output logic                   timer_output_pin,
    // event pulses toward the interrupt controller
    output logic                   match_a_irq,
    output logic                   match_b_irq,
    output logic                   capture_a_irq,
    output logic                   capture_b_irq
);
    import cct_pkg::*;

    if (CNT_W < 2 || CNT_W > 16) begin : g_chk_cnt
        $error("counter width must lie between 2 and 16");
    end
    if (ADDR_W < 6 || ADDR_W > 32) begin : g_chk_addr
        $error("address width must cover the register map");
    end

    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    function automatic cct_reg_e cct_decode(input logic [ADDR_W-1:0] addr);
        logic [31:0] wide;
        wide = 32'(addr);
        if (wide[31:8] != '0) begin
            return CCT_R_NONE;
        end
        case (wide[7:0])
            `CCT_OFF_RUN:  return CCT_R_RUN;
            `CCT_OFF_MODE: return CCT_R_MODE;
            `CCT_OFF_FLOP: return CCT_R_FLOP;
            `CCT_OFF_CMPA: return CCT_R_CMPA;
            `CCT_OFF_CMPB: return CCT_R_CMPB;
            `CCT_OFF_CAPA: return CCT_R_CAPA;
            `CCT_OFF_CAPB: return CCT_R_CAPB;
            `CCT_OFF_CNT:  return CCT_R_CNT;
            `CCT_OFF_STAT: return CCT_R_STAT;
            default:       return CCT_R_NONE;
        endcase
    endfunction : cct_decode

    function automatic cct_word_t cct_merge(input cct_word_t old_v, input cct_word_t new_v,
                                            input logic [3:0] strb);
        cct_word_t res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction : cct_merge

    // register bus state
    cct_wr_e           wr_state_r;
    logic              aw_got_r;
    logic              w_got_r;
    logic [ADDR_W-1:0] waddr_r;
    cct_word_t         wdata_r;
    logic [3:0]        wstrb_r;
    logic              wr_fire;
    cct_reg_e          wr_sel;
    cct_word_t         wr_word;

    // control and status registers
    logic [7:0]        run_r;
    logic [7:0]        mode_r;
    logic [2:0]        tog_en_r;
    logic [CNT_W-1:0]  cmpa_r;
    logic [CNT_W-1:0]  cmpa_buf_r;
    logic [CNT_W-1:0]  cmpb_r;
    logic [CNT_W-1:0]  capa_r;
    logic [CNT_W-1:0]  capb_r;
    logic [CNT_W-1:0]  up_counter_r;
    logic              cnt_upd_r;
    logic              started_r;
    logic              ovf_r;
    logic              flop_r;
    logic              pin_prev_r;

    // derived controls and events
    logic [`CCT_PRS_TAPS-1:0] pre_tick;
    logic              run_en;
    logic [1:0]        capture_mode_select;
    logic              pin_rise;
    logic              pin_fall;
    logic              cnt_tick;
    logic              cnt_step;
    logic              clear_hit;
    logic              match_a_ev;
    logic              match_b_ev;
    logic              soft_cap;
    logic              cap_a_ev;
    logic              cap_b_ev;
    logic              trig_b_ev;
    logic              flop_toggle;

    cct_prescaler #(
        .DIV_W (`CCT_PRS_DIV_W),
        .NTAP  (`CCT_PRS_TAPS)
    ) u_prescaler (
        .clk    (clk),
        .nrst   (nrst),
        .enable (run_r[`CCT_RUN_EN] & run_r[`CCT_RUN_PRS]),
        .tick   (pre_tick)
    );

    assign run_en   = run_r[`CCT_RUN_EN];
    assign capture_mode_select      = mode_r[`CCT_MODE_CPM_LO +: 2];
    assign pin_rise = timer_input_pin & ~pin_prev_r;
    assign pin_fall = ~timer_input_pin & pin_prev_r;

    // count source: input pin edges or one selected prescaler tick
    assign cnt_tick = run_r[`CCT_RUN_CSS] ? pin_rise
                                          : pre_tick[mode_r[`CCT_MODE_CLK_LO +: 2]];
    // external start holds the counter until the first rising edge
    assign cnt_step = run_en & cnt_tick
                    & (~run_r[`CCT_RUN_TRG] | started_r | pin_rise);
    assign clear_hit = mode_r[`CCT_MODE_CLE] & (up_counter_r == cmpb_r);

    // comparators look only at a freshly updated count, so a stopped counter fires once
    assign match_a_ev = cnt_upd_r & (up_counter_r == cmpa_r) & (cmpa_r != '0);
    assign match_b_ev = cnt_upd_r & (up_counter_r == cmpb_r)
                      & (mode_r[`CCT_MODE_CLE] | tog_en_r[1]);

    assign wr_sel   = cct_decode(waddr_r);
    assign wr_fire  = (wr_state_r == CCT_WR_IDLE) & aw_got_r & w_got_r;
    assign soft_cap = wr_fire & (wr_sel == CCT_R_MODE) & wstrb_r[0]
                    & wdata_r[`CCT_MODE_SWCAP];
    always_comb begin
        wr_word = '0;
        case (wr_sel)
            CCT_R_RUN:  wr_word = cct_merge({24'h0, run_r}, wdata_r, wstrb_r);
            CCT_R_MODE: wr_word = cct_merge({24'h0, mode_r}, wdata_r, wstrb_r);
            CCT_R_CMPA: wr_word = cct_merge({{(32-CNT_W){1'b0}}, cmpa_buf_r}, wdata_r, wstrb_r);
            CCT_R_CMPB: wr_word = cct_merge({{(32-CNT_W){1'b0}}, cmpb_r}, wdata_r, wstrb_r);
            default:    wr_word = wdata_r;
        endcase
    end

    assign cap_a_ev  = soft_cap
                     | ((capture_mode_select != `CCT_CPM_OFF) & pin_rise);
    assign cap_b_ev  = (capture_mode_select == `CCT_CPM_RISE_FALL) & pin_fall;
    assign trig_b_ev = (capture_mode_select == `CCT_CPM_TRIG) & pin_rise;

    // simultaneous triggers cancel in pairs, as two toggles would
    assign flop_toggle = (match_a_ev & tog_en_r[0])
                       ^ (match_b_ev & tog_en_r[1])
                       ^ (cap_a_ev & tog_en_r[2]);

    // axi write channel: address and data taken in either order
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_state_r    <= CCT_WR_IDLE;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            waddr_r       <= '0;
            wdata_r       <= '0;
            wstrb_r       <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CCT_RESP_OKAY;
        end else begin
            case (wr_state_r)
                CCT_WR_IDLE: begin
                    if (s_axi_awvalid && s_axi_awready) begin
                        waddr_r       <= s_axi_awaddr;
                        aw_got_r      <= 1'b1;
                        s_axi_awready <= 1'b0;
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        wdata_r      <= s_axi_wdata;
                        wstrb_r      <= s_axi_wstrb;
                        w_got_r      <= 1'b1;
                        s_axi_wready <= 1'b0;
                    end
                    if (wr_fire) begin
                        wr_state_r   <= CCT_WR_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= (wr_sel == CCT_R_NONE) ? `CCT_RESP_SLVERR
                                                               : `CCT_RESP_OKAY;
                    end
                end
                CCT_WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state_r    <= CCT_WR_IDLE;
                        s_axi_bvalid  <= 1'b0;
                        aw_got_r      <= 1'b0;
                        w_got_r       <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready  <= 1'b1;
                    end
                end
                default: begin
                    wr_state_r <= CCT_WR_IDLE;
                end
            endcase
        end
    end

    // axi read channel: data one cycle after the address is taken
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `CCT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `CCT_RESP_OKAY;
            case (cct_decode(s_axi_araddr))
                CCT_R_RUN:  s_axi_rdata <= {24'h0, run_r};
                CCT_R_MODE: s_axi_rdata <= {24'h0, 1'b0, mode_r[6:0] & 7'h3f};
                CCT_R_FLOP: s_axi_rdata <= {25'h0, flop_r, 1'b0, tog_en_r, `CCT_OP_KEEP};
                CCT_R_CMPA: s_axi_rdata <= {{(32-CNT_W){1'b0}}, cmpa_r};
                CCT_R_CMPB: s_axi_rdata <= {{(32-CNT_W){1'b0}}, cmpb_r};
                CCT_R_CAPA: s_axi_rdata <= {{(32-CNT_W){1'b0}}, capa_r};
                CCT_R_CAPB: s_axi_rdata <= {{(32-CNT_W){1'b0}}, capb_r};
                CCT_R_CNT:  s_axi_rdata <= {{(32-CNT_W){1'b0}}, up_counter_r};
                CCT_R_STAT: s_axi_rdata <= {29'h0, flop_r, started_r, ovf_r};
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= `CCT_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // run, mode and toggle-enable registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            run_r    <= `CCT_RST_RUN;
            mode_r   <= `CCT_RST_MODE;
            tog_en_r <= `CCT_RST_TOG;
        end else if (wr_fire) begin
            if (wr_sel == CCT_R_RUN) begin
                run_r <= wr_word[7:0];
            end
            if (wr_sel == CCT_R_MODE) begin
                // the capture command bit is a strobe and is never stored
                mode_r <= {2'b00, wr_word[5:0]};
            end
            if (wr_sel == CCT_R_FLOP && wstrb_r[0]) begin
                tog_en_r <= wdata_r[`CCT_FLOP_TOGA +: 3];
            end
        end
    end

    // compare registers with optional buffer in front of compare A
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cmpa_r     <= '0;
            cmpa_buf_r <= '0;
            cmpb_r     <= '0;
        end else begin
            if (wr_fire && wr_sel == CCT_R_CMPA) begin
                cmpa_buf_r <= wr_word[CNT_W-1:0];
                if (!run_r[`CCT_RUN_DBUF]) begin
                    cmpa_r <= wr_word[CNT_W-1:0];
                end
            end else if (run_r[`CCT_RUN_DBUF] && match_b_ev) begin
                cmpa_r <= cmpa_buf_r;
            end
            if (wr_fire && wr_sel == CCT_R_CMPB) begin
                cmpb_r <= wr_word[CNT_W-1:0];
            end
        end
    end

    // up-counter; stopping the timer clears it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            up_counter_r <= '0;
            cnt_upd_r    <= 1'b0;
        end else begin
            cnt_upd_r <= cnt_step;
            if (!run_en) begin
                up_counter_r <= '0;
            end else if (cnt_step) begin
                if (clear_hit) begin
                    up_counter_r <= '0;
                end else begin
                    up_counter_r <= up_counter_r + 1'b1;
                end
            end
        end
    end

    // external start latch and input edge history
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            started_r  <= 1'b0;
            pin_prev_r <= 1'b0;
        end else begin
            pin_prev_r <= timer_input_pin;
            if (!run_en || !run_r[`CCT_RUN_TRG]) begin
                started_r <= 1'b0;
            end else if (pin_rise) begin
                started_r <= 1'b1;
            end
        end
    end

    // sticky overflow, write one to clear; a new overflow beats the clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ovf_r <= 1'b0;
        end else if (cnt_step && !clear_hit && up_counter_r == CNT_MAX) begin
            ovf_r <= 1'b1;
        end else if (wr_fire && wr_sel == CCT_R_STAT && wstrb_r[0]
                     && wdata_r[`CCT_STAT_OVF]) begin
            ovf_r <= 1'b0;
        end
    end

    // capture registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            capa_r <= '0;
            capb_r <= '0;
        end else begin
            if (cap_a_ev) begin
                capa_r <= up_counter_r;
            end
            if (cap_b_ev) begin
                capb_r <= up_counter_r;
            end
        end
    end

    // output flop; a software set or clear overrides hardware toggles that cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flop_r           <= `CCT_RST_FLOP;
            timer_output_pin <= `CCT_RST_FLOP;
        end else begin
            if (wr_fire && wr_sel == CCT_R_FLOP && wstrb_r[0]
                && wdata_r[`CCT_FLOP_OP_LO +: 2] != `CCT_OP_KEEP) begin
                case (wdata_r[`CCT_FLOP_OP_LO +: 2])
                    `CCT_OP_SET:    flop_r <= 1'b1;
                    `CCT_OP_CLEAR:  flop_r <= 1'b0;
                    `CCT_OP_TOGGLE: flop_r <= ~flop_r;
                    default:        flop_r <= flop_r;
                endcase
            end else if (flop_toggle) begin
                flop_r <= ~flop_r;
            end
            // the pin trails the flop by one cycle so it comes straight from a flop
            timer_output_pin <= flop_r;
        end
    end

    // event pulses for the interrupt controller
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            match_a_irq   <= 1'b0;
            match_b_irq   <= 1'b0;
            capture_a_irq <= 1'b0;
            capture_b_irq <= 1'b0;
        end else begin
            match_a_irq   <= match_a_ev & (capture_mode_select == `CCT_CPM_OFF);
            match_b_irq   <= match_b_ev;
            capture_a_irq <= cap_a_ev;
            capture_b_irq <= cap_b_ev | trig_b_ev;
        end
    end

endmodule : cct_timer

/* sim/cct_chk.sv */
// bus handshake and capture-pin assertions for the timer channel
`timescale 1ns/1ps
module cct_chk (
    // clock and reset
    input wire logic clk, nrst,
    // bus handshakes
    input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic s_axi_rvalid, s_axi_rready,
    // pin and event
    input wire logic timer_input_pin, capture_a_irq, capture_b_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_rd_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rd_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_b_after: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
    a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    // a trigger capture raises both events together, a falling-edge capture only B
    a_cap_rise: assert property (capture_b_irq && capture_a_irq |-> $past(timer_input_pin)
        && !$past(timer_input_pin, 2)) else $error("capture event without rise");
    a_cap_fall: assert property (capture_b_irq && !capture_a_irq |-> !$past(timer_input_pin)
        && $past(timer_input_pin, 2)) else $error("capture B without fall");
    a_cap_once: assert property (capture_b_irq |=> !capture_b_irq)
        else $error("capture event too long");
    // main scenarios
    cover property (capture_b_irq);
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
endmodule : cct_chk

bind cct_timer cct_chk u_chk (.*);

/* sim/cct_pin_src.sv */
// pulse source on the timer input pin: high for hi cycles, then low as long
`timescale 1ns/1ps
module cct_pin_src (
    input wire logic       clk,
    input wire logic       go,
    input wire logic [7:0] hi,
    output logic           pin
);
    logic [8:0] c_r;
    initial c_r = 9'h000;
    // low gap keeps pulses apart so every rise is seen
    always @(posedge clk) c_r <= (go && c_r == 0) ? {hi, 1'b0} : (c_r != 0 ? c_r - 1 : 0);
    assign pin = c_r > {1'b0, hi};
endmodule : cct_pin_src

/* sim/testbench.sv */
// self-checking bench for the timer channel
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    logic clk, nrst, awv, wv, bry, arv, rry, go, pin, awr, wr_, bv, arr, rv, ma, mb, ca, cb, po;
    logic [7:0] awa, ara, hi;
    logic [31:0] wd, rdt, d, e;
    logic [1:0] br, rr, r, bq;
    int seed, miscompares, checks, na, nb, nca, ncb, c, k, h, p, q;
    logic p1;
    cct_timer uut (.clk(clk), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .timer_input_pin(pin),
        .timer_output_pin(po), .match_a_irq(ma), .match_b_irq(mb), .capture_a_irq(ca),
        .capture_b_irq(cb));
    cct_pin_src src (.clk(clk), .go(go), .hi(hi), .pin(pin));
    initial begin clk = 0; forever #4 clk = ~clk; end
    always @(posedge clk) begin na <= na + ma; nb <= nb + mb; end
    always @(posedge clk) begin nca <= nca + ca; ncb <= ncb + cb; end
    function automatic int per(input int b); return 2 * (b + 1); endfunction : per
    task close_out();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        @(posedge clk); awa <= a; wd <= v; awv <= 1; wv <= 1; bry <= 1; n = 0;
        do begin @(posedge clk); if (awr) awv <= 0; if (wr_) wv <= 0; n++; end
        while (!bv && n < 50);
        bq = br; bry <= 0; if (n >= 50) miscompares++;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge clk); ara <= a; arv <= 1; rry <= 1; n = 0;
        do begin @(posedge clk); if (arr) arv <= 0; n++; end while (!rv && n < 50);
        d = rdt; r = rr; rry <= 0; if (n >= 50) miscompares++;
    endtask : rd
    task automatic pulse(input int w);
        @(posedge clk); go <= 1; hi <= w[7:0]; @(posedge clk); go <= 0;
        repeat (2 * w + 2) @(posedge clk);
    endtask : pulse
    task automatic wirq();
        c = 0; do begin @(posedge clk); c++; end while (!mb && c < 200);
        if (c >= 200) miscompares++;
    endtask : wirq
    initial begin
        seed = 58; miscompares = 0; checks = 0; na = 0; nb = 0; nca = 0; ncb = 0; nrst = 0;
        go = 0; hi = 0;
        awv = 0; wv = 0; bry = 0; arv = 0; rry = 0; awa = 0; ara = 0; wd = 0;
        repeat (20) @(posedge clk); nrst <= 1;
        rd(8'h1c); `CHK(d, 32'h0)
        rd(8'h24); `CHK(r, 2'b10)
        wr(8'h24, 0); `CHK(bq, 2'b10)
        // interval: clear on B match, toggle on B, compare A left at zero
        wr(8'h10, 2); wr(8'h0c, 0); wr(8'h04, 32'h4); wr(8'h08, 32'hb); wr(8'h00, 32'h5);
        wirq(); p1 = po; wirq();
        `CHK(c, per(2))
        `CHK(po, ~p1)
        `CHK(na, 0)
        // pulse mode with a buffered compare A
        wr(8'h00, 0); wr(8'h10, 8); wr(8'h0c, 2); wr(8'h08, 32'he);
        wr(8'h00, 32'h85); wr(8'h0c, 3); rd(8'h0c); `CHK(d, 2)
        wirq(); `CHK(po, 1)
        @(posedge clk); `CHK(po, 0)
        rd(8'h0c); `CHK(d, 3)
        // counting pin edges, plain and with external start
        foreach (e[i]) if (i == 5 || i == 6) begin
            wr(8'h00, 0); wr(8'h04, 0); wr(8'h00, i == 5 ? 32'h41 : 32'h61);
            k = 1 + {$random(seed)} % 6;
            repeat (k) pulse(1 + {$random(seed)} % 4);
            wr(8'h04, 32'h40); rd(8'h14); `CHK(d, k)
        end
        // external start holds the prescaled count until a rise
        wr(8'h00, 0); wr(8'h00, 32'h25); repeat (10) @(posedge clk);
        rd(8'h1c); `CHK(d, 32'h0)
        // high width measurement on a free-running count
        wr(8'h00, 0); wr(8'h04, 32'h08); wr(8'h00, 32'h5);
        h = 2 * (1 + {$random(seed)} % 8); pulse(h);
        rd(8'h14); e = d; rd(8'h18); `CHK(d - e, h / 2)
        // trigger capture raises one capture-B event
        wr(8'h04, 32'h10); wr(8'h08, 32'h12); k = ncb; h = nca; pulse(3); rd(8'h14);
        `CHK(ncb - k, 1)
        `CHK(nca - h, 1)
        `CHK(po, 1)
        // triggered one-shot: delay and width added to the captured count
        k = na; h = nb; wr(8'h0c, d + 40); wr(8'h10, d + 50);
        wr(8'h08, 32'he); wirq(); `CHK(po, 1)
        @(posedge clk); `CHK(po, 0)
        wr(8'h08, 32'h3);
        `CHK(na - k, 0)
        `CHK(nb - h, 1)
        // one-shot started by the first counted input edge
        wr(8'h00, 0); wr(8'h04, 0); q = 1 + {$random(seed)} % 3; p = 1 + {$random(seed)} % 3;
        wr(8'h0c, q); wr(8'h10, q + p); wr(8'h08, 32'he); wr(8'h00, 32'h61);
        k = na; h = nb; repeat (q) pulse(1 + {$random(seed)} % 4); `CHK(po, 1)
        repeat (p) pulse(2); `CHK(po, 0)
        wr(8'h08, 32'h3);
        `CHK(na - k, 1)
        `CHK(nb - h, 1)
        close_out();
    end
    initial begin repeat (20000) @(posedge clk); miscompares++; close_out(); end
endmodule : testbench
